// >>> fpm_top.sv
// fpm_top.sv: front panel menu controller with axi4-lite registers
// assumes raw switch contacts, pll lock pins and a non-volatile store
`include "fpm_defs.svh"
// Behaviour
// - twelve menu items, optional ones skipped
// - menu press advances to next item
// - save prompt after last item or return
// - commit only on confirmed menu session
// - twelve second idle abandons session
// - yes stores, no restores previous settings
// - frequencies applied only after yes
// - level and gain applied live, stored on yes
// - horizontal rocker moves cursor among digits
// - vertical rocker steps digit under cursor
// - vertical rocker toggles on/off items
// - input level -40 to -10, 1 dB
// - up gain -10 to +30 per digit
// - down gain 0 to +50, 1/10 dB
// - committed settings survive power loss
// - power-up lamp test, version, then values
// - alarm on any synthesizer unlock
module fpm_top #(
   parameter logic [31:0] TIMEOUT_CYC = 32'(`FPM_S_CYC(`FPM_TIMEOUT_S)),
   parameter logic [31:0] DEB_CYC     = 32'(`FPM_MS_CYC(`FPM_DEBOUNCE_MS)),
   parameter logic [31:0] LAMP_CYC    = 32'(`FPM_MS_CYC(`FPM_LAMP_MS)),
   parameter logic [31:0] VER_CYC     = 32'(`FPM_MS_CYC(`FPM_VERSION_MS)),
   parameter logic [31:0] FW_VERSION  = 32'h0000_0101 // arbitrary value
) (
   input  wire logic        sys_clk,
   input  wire logic        sys_rst,
   input  wire logic [3:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [4:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        sw_menu,
   input  wire logic        sw_left,
   input  wire logic        sw_right,
   input  wire logic        sw_up,
   input  wire logic        sw_down,
   input  wire logic        up_pll_lock,
   input  wire logic        dn_pll_lock,
   input  wire logic [58:0] nv_rd_data,
   output logic [58:0]      nv_wr_data,
   output logic             nv_wr_en,
   output fpm_pkg::fpm_set_t path_set,
   output logic [3:0]       disp_state,
   output logic [3:0]       disp_item,
   output logic [2:0]       disp_cursor,
   output logic             disp_save_yes,
   output logic             alarm_indicator,
   output logic             power_indicator,
   output logic             irq
);
   // ************************************************************
   // switches and lock inputs
   // ************************************************************
   logic [4:0] pins;
   logic [4:0] pr;
   logic [1:0] lk1_q;
   logic [1:0] lk2_q;
   assign pins = {sw_down, sw_up, sw_right, sw_left, sw_menu};
   for (genvar i = 0; i < 5; i++) begin : g_sw
      fpm_switch #(.DEB_CYC(DEB_CYC)) u_sw (
         .sys_clk (sys_clk),
         .sys_rst (sys_rst),
         .pin     (pins[i]),
         .press   (pr[i])
      );
   end
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         lk1_q <= 2'h3;
         lk2_q <= 2'h3;
      end else begin
         lk1_q <= {dn_pll_lock, up_pll_lock};
         lk2_q <= lk1_q;
      end
   end

   // ************************************************************
   // registers of the bus
   // ************************************************************
   fpm_pkg::fpm_state_t st_q;
   fpm_pkg::fpm_set_t   wk_q;
   fpm_pkg::fpm_set_t   cm_q;
   logic [2:0]  ctrl_q;
   logic [3:0]  stat_q;
   logic [3:0]  ien_q;
   logic [3:0]  clr;
   logic [3:0]  ev;
   logic        wr_go;
   logic [3:0]  item_q;
   logic [2:0]  cur_q;
   logic        yes_q;
   logic [31:0] rd;
   logic        rd_ok;
   assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_awready
                  && !s_axi_bvalid;
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= 2'h0;
      end else begin
         s_axi_awready <= wr_go;
         s_axi_wready  <= wr_go;
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (s_axi_awaddr > 4'(`FPM_REG_IRQ_CLR)) ?
                            2'h2 : 2'h0;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         ctrl_q <= 3'h0;
         ien_q  <= 4'h0;
      end else if (wr_go && s_axi_wstrb[0]) begin
         if (s_axi_awaddr == 4'(`FPM_REG_CTRL)) begin
            ctrl_q <= s_axi_wdata[2:0];
         end else if (s_axi_awaddr == 4'(`FPM_REG_IRQ_EN)) begin
            ien_q <= s_axi_wdata[3:0];
         end
      end
   end
   assign clr = (wr_go && s_axi_wstrb[0] &&
                 s_axi_awaddr == 4'(`FPM_REG_IRQ_CLR)) ?
                s_axi_wdata[3:0] : 4'h0;
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         stat_q <= 4'h0;
         irq    <= 1'b0;
      end else begin
         stat_q <= (stat_q & ~clr) | ev;
         irq    <= |(((stat_q & ~clr) | ev) & ien_q);
      end
   end
   always_comb begin
      rd    = 32'h0;
      rd_ok = 1'b1;
      if (s_axi_araddr == 5'(`FPM_REG_CTRL)) begin
         rd = {29'h0, ctrl_q};
      end else if (s_axi_araddr == 5'(`FPM_REG_STATUS)) begin
         rd = {28'h0, stat_q};
      end else if (s_axi_araddr == 5'(`FPM_REG_IRQ_EN)) begin
         rd = {28'h0, ien_q};
      end else if (s_axi_araddr == 5'(`FPM_REG_IRQ_CLR)) begin
         rd = 32'h0;
      end else if (s_axi_araddr == 5'(`FPM_REG_FREQ)) begin
         rd = {4'h0, cm_q.up_freq, 5'h0, cm_q.dn_freq};
      end else if (s_axi_araddr == 5'(`FPM_REG_LEVEL)) begin
         rd = {8'h0, wk_q.up_lvl, wk_q.up_gain, wk_q.dn_gain};
      end else if (s_axi_araddr == 5'(`FPM_REG_MENU)) begin
         rd = {16'h0, st_q, item_q, yes_q, cur_q, 2'h0, lk2_q};
      end else if (s_axi_araddr == 5'(`FPM_REG_VERSION)) begin
         rd = FW_VERSION;
      end else begin
         rd_ok = 1'b0;
      end
   end
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0;
         s_axi_rresp   <= 2'h0;
      end else begin
         s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
         if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd;
            s_axi_rresp  <= rd_ok ? 2'h0 : 2'h2;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ************************************************************
   // menu walk and editing
   // ************************************************************
   logic              boot_q;
   logic [31:0]       tmr_q;
   logic [31:0]       idle_q;
   logic [3:0]        nxt;
   logic [2:0]        ndig;
   logic signed [12:0] val;
   logic signed [12:0] vmin;
   logic signed [12:0] vmax;
   logic signed [12:0] step;
   logic signed [12:0] nval;
   logic              act;
   logic              tmo;
   logic              commit;
   logic              revert;
   assign act    = |pr;
   assign tmo    = st_q == fpm_pkg::FPM_EDIT && idle_q >= TIMEOUT_CYC;
   assign commit = st_q == fpm_pkg::FPM_EDIT && pr[0]
                   && item_q == `FPM_IT_SAVE && yes_q;
   assign revert = tmo || (st_q == fpm_pkg::FPM_EDIT && pr[0]
                   && item_q == `FPM_IT_SAVE && !yes_q);
   assign ev     = {tmo, revert, commit, ~&lk2_q};
   always_comb begin
      nxt = item_q + 4'h1;
      if (nxt == `FPM_IT_EXTREF && !ctrl_q[0]) nxt = `FPM_IT_BUSMODE;
      if (nxt == `FPM_IT_BUSMODE && !ctrl_q[1]) nxt = `FPM_IT_TEMP;
      if (nxt == `FPM_IT_TEMP && !ctrl_q[2]) nxt = `FPM_IT_SAVE;
   end
   always_comb begin
      ndig = 3'h1;
      val  = 13'sd0;
      vmin = 13'sd0;
      vmax = 13'sd1;
      case (item_q)
         `FPM_IT_UPFREQ: begin
            ndig = 3'h4;
            val  = 13'(wk_q.up_freq);
            vmin = `FPM_UPF_MIN;
            vmax = `FPM_UPF_MAX;
         end
         `FPM_IT_UPLVL: begin
            val  = 13'(signed'(wk_q.up_lvl));
            vmin = `FPM_LVL_MIN;
            vmax = `FPM_LVL_MAX;
         end
         `FPM_IT_UPGAIN: begin
            ndig = 3'h2;
            val  = 13'(signed'(wk_q.up_gain));
            vmin = `FPM_UPG_MIN;
            vmax = `FPM_UPG_MAX;
         end
         `FPM_IT_DNFREQ: begin
            ndig = 3'h4;
            val  = 13'(wk_q.dn_freq);
            vmin = `FPM_DNF_MIN;
            vmax = `FPM_DNF_MAX;
         end
         `FPM_IT_DNGAIN: begin
            ndig = 3'h2;
            val  = 13'(wk_q.dn_gain);
            vmin = `FPM_DNG_MIN;
            vmax = `FPM_DNG_MAX;
         end
         `FPM_IT_BUSADDR: begin
            ndig = 3'h2;
            val  = 13'(wk_q.bus_addr);
            vmin = `FPM_ADR_MIN;
            vmax = `FPM_ADR_MAX;
         end
         `FPM_IT_TEMP: ndig = 3'h0;
         `FPM_IT_SAVE: ndig = 3'h0;
         default: ndig = 3'h1;
      endcase
      case (3'(ndig - 3'h1 - cur_q))
         3'h1: step = 13'sd10;
         3'h2: step = 13'sd100;
         3'h3: step = 13'sd1000;
         default: step = 13'sd1;
      endcase
      nval = pr[3] ? val + step : val - step;
      if (nval > vmax) nval = vmax;
      if (nval < vmin) nval = vmin;
   end
   // state, power-up sequence and idle timer
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         st_q   <= fpm_pkg::FPM_LAMP;
         tmr_q  <= 32'h0;
         idle_q <= 32'h0;
      end else begin
         tmr_q  <= tmr_q + 32'h1;
         idle_q <= act ? 32'h0 : idle_q + 32'h1;
         case (st_q)
            fpm_pkg::FPM_LAMP: if (tmr_q >= LAMP_CYC - 32'h1) begin
               st_q  <= fpm_pkg::FPM_VER;
               tmr_q <= 32'h0;
            end
            fpm_pkg::FPM_VER: if (tmr_q >= VER_CYC - 32'h1) begin
               st_q <= fpm_pkg::FPM_NORMAL;
            end
            fpm_pkg::FPM_NORMAL: if (pr[0]) begin
               st_q   <= fpm_pkg::FPM_EDIT;
               idle_q <= 32'h0;
            end
            fpm_pkg::FPM_EDIT: if (commit || revert) begin
               st_q <= fpm_pkg::FPM_NORMAL;
            end
            default: st_q <= fpm_pkg::FPM_LAMP;
         endcase
      end
   end
   // item, cursor and save choice
   always_ff @(posedge sys_clk) begin
      if (sys_rst || st_q != fpm_pkg::FPM_EDIT) begin
         item_q <= `FPM_IT_UPFREQ;
         cur_q  <= 3'h0;
         yes_q  <= 1'b1;
      end else if (pr[0] && item_q != `FPM_IT_SAVE) begin
         cur_q <= 3'h0;
         yes_q <= 1'b1;
         if (cur_q == ndig) begin
            item_q <= `FPM_IT_SAVE;
         end else begin
            item_q <= nxt;
         end
      end else if (pr[1] && cur_q != 3'h0) begin
         cur_q <= cur_q - 3'h1;
      end else if (pr[2] && cur_q < ndig) begin
         cur_q <= cur_q + 3'h1;
      end else if ((pr[3] || pr[4]) && item_q == `FPM_IT_SAVE) begin
         yes_q <= !yes_q;
      end
   end
   // working and committed copies, non-volatile store
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         boot_q <= 1'b1;
         cm_q   <= '0;
         wk_q   <= '0;
         nv_wr_en <= 1'b0;
         nv_wr_data <= '0;
      end else begin
         boot_q   <= 1'b0;
         nv_wr_en <= 1'b0;
         if (boot_q) begin
            cm_q <= nv_rd_data[56:0];
            wk_q <= nv_rd_data[56:0];
         end else if (commit) begin
            cm_q       <= wk_q;
            nv_wr_data <= {2'h0, wk_q};
            nv_wr_en   <= 1'b1;
         end else if (revert || st_q != fpm_pkg::FPM_EDIT) begin
            wk_q <= cm_q;
         end else if ((pr[3] || pr[4]) && cur_q != ndig) begin
            case (item_q)
               `FPM_IT_UPFREQ: wk_q.up_freq <= nval[11:0];
               `FPM_IT_UPLVL:  wk_q.up_lvl  <= nval[7:0];
               `FPM_IT_UPGAIN: wk_q.up_gain <= nval[7:0];
               `FPM_IT_DNFREQ: wk_q.dn_freq <= nval[10:0];
               `FPM_IT_DNGAIN: wk_q.dn_gain <= nval[7:0];
               `FPM_IT_MUTE:   wk_q.mute    <= !wk_q.mute;
               `FPM_IT_REMOTE: wk_q.remote  <= !wk_q.remote;
               `FPM_IT_SPEC:   wk_q.spec_inv <= !wk_q.spec_inv;
               `FPM_IT_EXTREF: wk_q.ext_ref <= !wk_q.ext_ref;
               `FPM_IT_BUSMODE: wk_q.bus_mode <= !wk_q.bus_mode;
               `FPM_IT_BUSADDR: wk_q.bus_addr <= nval[4:0];
               default: wk_q <= wk_q;
            endcase
         end
      end
   end
   // signal path and indicators
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         path_set        <= '0;
         alarm_indicator <= 1'b0;
         power_indicator <= 1'b0;
         disp_state      <= 4'h0;
         disp_item       <= 4'h0;
         disp_cursor     <= 3'h0;
         disp_save_yes   <= 1'b0;
      end else begin
         path_set         <= cm_q;
         path_set.up_lvl  <= wk_q.up_lvl;
         path_set.up_gain <= wk_q.up_gain;
         path_set.dn_gain <= wk_q.dn_gain;
         alarm_indicator  <= ~&lk2_q;
         power_indicator  <= 1'b1;
         disp_state       <= st_q;
         disp_item        <= item_q;
         disp_cursor      <= cur_q;
         disp_save_yes    <= yes_q;
      end
   end

   // ************************************************************
   // checks
   // ************************************************************
   property p_lock;
      @(posedge sys_clk) disable iff (sys_rst)
      !(&lk2_q) |=> alarm_indicator;
   endproperty
   a_lock: assert property (p_lock) else $error("alarm missing");
   property p_freq;
      @(posedge sys_clk) disable iff (sys_rst)
      $changed(path_set.up_freq) |-> $past(commit, 2) || $past(boot_q, 2);
   endproperty
   a_freq: assert property (p_freq) else $error("freq live");
   property p_gain;
      @(posedge sys_clk) disable iff (sys_rst)
      1'b1 |=> path_set.up_gain == $past(wk_q.up_gain);
   endproperty
   a_gain: assert property (p_gain) else $error("gain not live");
   property p_save;
      @(posedge sys_clk) disable iff (sys_rst)
      commit |=> nv_wr_en && cm_q == $past(wk_q)
                 && st_q == fpm_pkg::FPM_NORMAL;
   endproperty
   a_save: assert property (p_save) else $error("save lost");
   property p_rev;
      @(posedge sys_clk) disable iff (sys_rst)
      revert |=> ##1 wk_q == cm_q;
   endproperty
   a_rev: assert property (p_rev) else $error("revert lost");
   property p_tmo;
      @(posedge sys_clk) disable iff (sys_rst)
      tmo |=> st_q == fpm_pkg::FPM_NORMAL && stat_q[`FPM_ST_TIMEOUT];
   endproperty
   a_tmo: assert property (p_tmo) else $error("timeout lost");
   property p_nv;
      @(posedge sys_clk) disable iff (sys_rst)
      nv_wr_en |-> $past(commit);
   endproperty
   a_nv: assert property (p_nv) else $error("stray store");
   property p_lvl;
      @(posedge sys_clk) disable iff (sys_rst || boot_q)
      st_q == fpm_pkg::FPM_EDIT |-> signed'(wk_q.up_lvl) >= -8'sd40
                                    && signed'(wk_q.up_lvl) <= -8'sd10;
   endproperty
   a_lvl: assert property (p_lvl) else $error("level range");
   property p_ver;
      @(posedge sys_clk) disable iff (sys_rst)
      st_q == fpm_pkg::FPM_VER |=> st_q != fpm_pkg::FPM_LAMP;
   endproperty
   a_ver: assert property (p_ver) else $error("power-up order");
   property p_adv;
      @(posedge sys_clk) disable iff (sys_rst)
      st_q == fpm_pkg::FPM_EDIT && pr[0] && item_q != `FPM_IT_SAVE
      && cur_q != ndig |=> item_q == $past(nxt);
   endproperty
   a_adv: assert property (p_adv) else $error("no advance");
endmodule

// >>> fpm_defs.svh
// fpm_defs.svh: offsets, field positions, reset values and timing counts
// assumes a 200 MHz sys_clk and an axi4-lite bus with 32-bit data
`ifndef FPM_DEFS_SVH
`define FPM_DEFS_SVH
// ************************************************************
// timing
// ************************************************************
`define FPM_CLK_HZ        200000000
`define FPM_TIMEOUT_S     12
`define FPM_DEBOUNCE_MS   10
`define FPM_LAMP_MS       1000
`define FPM_VERSION_MS    1000
`define FPM_MS_CYC(ms)    ((ms) * 64'd200000 * 64'd1)
`define FPM_S_CYC(s)      ((s) * 64'd200000000)
// ************************************************************
// register offsets
// ************************************************************
`define FPM_REG_CTRL      8'h00
`define FPM_REG_STATUS    8'h04
`define FPM_REG_IRQ_EN    8'h08
`define FPM_REG_IRQ_CLR   8'h0C
`define FPM_REG_FREQ      8'h10
`define FPM_REG_LEVEL     8'h14
`define FPM_REG_MENU      8'h18
`define FPM_REG_VERSION   8'h1C
// ************************************************************
// status bits and menu items
// ************************************************************
`define FPM_ST_UNLOCK     0
`define FPM_ST_SAVED      1
`define FPM_ST_REVERTED   2
`define FPM_ST_TIMEOUT    3
`define FPM_IT_UPFREQ     4'h1
`define FPM_IT_UPLVL      4'h2
`define FPM_IT_UPGAIN     4'h3
`define FPM_IT_DNFREQ     4'h4
`define FPM_IT_DNGAIN     4'h5
`define FPM_IT_MUTE       4'h6
`define FPM_IT_REMOTE     4'h7
`define FPM_IT_SPEC       4'h8
`define FPM_IT_EXTREF     4'h9
`define FPM_IT_BUSMODE    4'hA
`define FPM_IT_BUSADDR    4'hB
`define FPM_IT_TEMP       4'hC
`define FPM_IT_SAVE       4'hD
// ************************************************************
// ranges and defaults
// ************************************************************
`define FPM_UPF_MIN       13'sd2000
`define FPM_UPF_MAX       13'sd2700
`define FPM_DNF_MIN       13'sd950
`define FPM_DNF_MAX       13'sd1750
`define FPM_LVL_MIN       -13'sd40
`define FPM_LVL_MAX       -13'sd10
`define FPM_UPG_MIN       -13'sd10
`define FPM_UPG_MAX       13'sd30
`define FPM_DNG_MIN       13'sd0
`define FPM_DNG_MAX       13'sd50
`define FPM_ADR_MIN       13'sd0
`define FPM_ADR_MAX       13'sd31
`define FPM_DEF_UPF       12'h8CA
`define FPM_DEF_DNF       11'h4B0
`define FPM_DEF_LVL       8'hEC
`define FPM_DEF_UPG       8'h0A
`define FPM_DEF_DNG       8'h19
`endif

// >>> fpm_pkg.sv
// fpm_pkg.sv: types of the front panel menu controller
// assumes nothing from fpm_defs.svh; state codes and field widths are set here
package fpm_pkg;
   typedef enum logic [3:0] {
      FPM_LAMP   = 4'b0001,
      FPM_VER    = 4'b0010,
      FPM_NORMAL = 4'b0100,
      FPM_EDIT   = 4'b1000
   } fpm_state_t;
   typedef struct packed {
      logic [11:0] up_freq;
      logic [7:0]  up_lvl;
      logic [7:0]  up_gain;
      logic [10:0] dn_freq;
      logic [7:0]  dn_gain;
      logic        mute;
      logic        remote;
      logic        spec_inv;
      logic        ext_ref;
      logic        bus_mode;
      logic [4:0]  bus_addr;
   } fpm_set_t;
endpackage

// >>> fpm_switch.sv
// fpm_switch.sv: synchroniser and debouncer for one panel switch contact
// assumes an asynchronous active high contact level on pin
module fpm_switch #(
   parameter logic [31:0] DEB_CYC = 32'h001E_8480
) (
   input  wire logic sys_clk,
   input  wire logic sys_rst,
   input  wire logic pin,
   output logic      press
);
   logic        s1_q;
   logic        s2_q;
   logic        lvl_q;
   logic [31:0] cnt_q;

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
      end else begin
         s1_q <= pin;
         s2_q <= s1_q;
      end
   end

   // level must stay different for DEB_CYC cycles before it is taken
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         cnt_q <= 32'h0;
         lvl_q <= 1'b0;
         press <= 1'b0;
      end else begin
         press <= 1'b0;
         if (s2_q == lvl_q) begin
            cnt_q <= 32'h0;
         end else if (cnt_q >= DEB_CYC - 32'h1) begin
            cnt_q <= 32'h0;
            lvl_q <= s2_q;
            press <= s2_q;
         end else begin
            cnt_q <= cnt_q + 32'h1;
         end
      end
   end
endmodule

// >>> fpm_panel.sv
// fpm_panel.sv: operator switch contacts and settings store for fpm_top
// assumes the bench names the held switch, one bit each, active high
module fpm_panel (
   input  wire logic        sys_clk,
   input  wire logic [4:0]  hold,
   input  wire logic        nv_wr_en,
   input  wire logic [58:0] nv_wr_data,
   output logic [4:0]       contact,
   output logic [58:0]      nv_rd_data
);
   timeunit 1ns;
   timeprecision 1ps;
   // ************************************************************
   // contacts settle one cycle after the operator moves
   // ************************************************************
   initial contact = 5'h0;
   always @(posedge sys_clk) begin
      contact <= hold;
   end
   // ************************************************************
   // store keeps its word with power off, written on save
   // ************************************************************
   initial nv_rd_data = {2'h0, 12'h8CA, 8'hEC, 8'h0A, 11'h4B0, 8'h19, 10'h0};
   always @(posedge sys_clk) begin
      if (nv_wr_en) begin
         nv_rd_data <= nv_wr_data;
      end
   end
endmodule

// >>> testbench.sv
// testbench.sv: random and corner tests of fpm_top through its panel
// assumes fpm_panel as operator and store, shortened timing parameters
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk, sys_rst, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid, up_lock, dn_lock;
   logic nv_we, yes, alarm, pwr, irq;
   logic [1:0] bresp, rresp, resp;
   logic [3:0] awaddr, dstate, item;
   logic [4:0] araddr, hold, contact;
   logic [2:0] cursor;
   logic [31:0] wdata, rdata, rd;
   logic [58:0] nv_rd, nv_wr;
   fpm_pkg::fpm_set_t path;
   int n_fail, check_count, seed, k, i, lvl;
   fpm_top #(.TIMEOUT_CYC(2000), .DEB_CYC(4), .LAMP_CYC(10), .VER_CYC(10))
   fpm_top_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .sw_menu(contact[0]), .sw_left(contact[1]),
      .sw_right(contact[2]), .sw_up(contact[3]), .sw_down(contact[4]),
      .up_pll_lock(up_lock), .dn_pll_lock(dn_lock), .nv_rd_data(nv_rd),
      .nv_wr_data(nv_wr), .nv_wr_en(nv_we), .path_set(path),
      .disp_state(dstate), .disp_item(item), .disp_cursor(cursor),
      .disp_save_yes(yes), .alarm_indicator(alarm), .power_indicator(pwr),
      .irq(irq));
   fpm_panel fpm_panel_i (.sys_clk(sys_clk), .hold(hold), .nv_wr_en(nv_we),
      .nv_wr_data(nv_wr), .contact(contact), .nv_rd_data(nv_rd));
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   // ************************************************************
   // checking, expectations and the closing report
   // ************************************************************
   task chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("Error at %0t: saw %h expected %h", $time, got, exp);
      end
   endtask
   function automatic logic [31:0] exp_lvl(input int v);
      if (v > -10) v = -10;
      if (v < -40) v = -40;
      return {24'h0, v[7:0]};
   endfunction
   task test_done;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // ************************************************************
   // bus cycles and switch presses
   // ************************************************************
   task axw(input logic [3:0] a, input logic [31:0] d);
      int n;
      awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge sys_clk);
         if (bvalid === 1'b1) break;
      end
      resp = bresp;
      awvalid <= 1'b0; wvalid <= 1'b0; bready <= 1'b0;
      if (n == 50) begin n_fail++; test_done(); end
   endtask
   task axr(input logic [4:0] a);
      int n;
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge sys_clk);
         if (rvalid === 1'b1) break;
      end
      rd = rdata;
      resp = rresp;
      arvalid <= 1'b0; rready <= 1'b0;
      if (n == 50) begin n_fail++; test_done(); end
   endtask
   task press(input int b);
      hold <= 5'h1 << b;
      repeat (12) @(posedge sys_clk);
      hold <= 5'h0;
      repeat (12) @(posedge sys_clk);
   endtask
   // ************************************************************
   // main sequence
   // ************************************************************
   initial begin
      {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
      awaddr = 4'h0; araddr = 5'h00; wdata = 32'h0; hold = 5'h0;
      up_lock = 1'b1; dn_lock = 1'b1; sys_rst = 1'b1;
      n_fail = 0; check_count = 0; seed = 35322; lvl = -20;
      repeat (12) @(posedge sys_clk);
      sys_rst <= 1'b0;
      repeat (5) @(posedge sys_clk);
      chk(dstate, 4'h1);
      repeat (10) @(posedge sys_clk);
      chk(dstate, 4'h2);
      repeat (15) @(posedge sys_clk);
      chk(dstate, 4'h4);
      chk(pwr, 1'b1);
      $display("power-up test done");
      for (i = 0; i < 2; i++) begin
         press(0);
         chk(item, 4'h1);
         press(0);
         chk(item, 4'h2);
         k = (i == 0) ? {$random(seed)} % 16 : -1;
         repeat ((k < 0) ? 1 : k) press((k < 0) ? 4 : 3);
         chk(path.up_lvl, exp_lvl(lvl + k));
         press(2);
         chk(cursor, 3'h1);
         press(0);
         chk(item, 4'hD);
         if (i == 1) press(3);
         chk(yes, i == 0);
         press(0);
         chk(dstate, 4'h4);
         if (i == 0) lvl = (lvl + k > -10) ? -10 : lvl + k;
         chk(path.up_lvl, exp_lvl(lvl));
      end
      axr(5'h04);
      chk(rd[2:1], 2'h3);
      chk(resp, 2'h0);
      $display("save and revert test done");
      press(0);
      press(3);
      chk(path.up_freq, 12'h8CA);
      repeat (2100) @(posedge sys_clk);
      chk(dstate, 4'h4);
      axr(5'h04);
      chk(rd[3], 1'b1);
      axw(4'h8, 32'h1);
      chk(resp, 2'h0);
      dn_lock <= 1'b0;
      repeat (8) @(posedge sys_clk);
      chk({alarm, irq}, 2'h3);
      dn_lock <= 1'b1;
      repeat (8) @(posedge sys_clk);
      axw(4'hC, 32'h1);
      repeat (3) @(posedge sys_clk);
      chk({alarm, irq}, 2'h0);
      $display("timeout and alarm test done");
      axw(4'h0, 32'h1);
      for (i = 1; i < 11; i++) begin
         press(0);
         chk(item, (i < 10) ? 4'(i) : 4'hD);
         if (i == 6) press(4);
      end
      chk(path.mute, 1'b0);
      press(0);
      chk(path.mute, 1'b1);
      $display("menu walk test done");
      sys_rst <= 1'b1;
      repeat (12) @(posedge sys_clk);
      sys_rst <= 1'b0;
      repeat (4) @(posedge sys_clk);
      chk(path.up_lvl, exp_lvl(lvl));
      chk(path.mute, 1'b1);
      $display("power loss test done");
      test_done();
   end
endmodule
